// ### udp_framer_consts.vh
// Constants for the point cloud UDP framer: header layout, tail layout,
// register offsets and timing counts. Included by both design files.
`ifndef UDP_FRAMER_CONSTS_VH
`define UDP_FRAMER_CONSTS_VH

// Frame layout in bytes.
`define HDR_LEN          11'd42
`define TAIL_LEN_SEQ     11'd26
`define TAIL_LEN_NOSEQ   11'd22
`define ETHTYPE_HI       8'h08
`define ETHTYPE_LO       8'h00
`define UDP_SRC_PORT     16'h2710
`define UDP_DST_PORT     16'h0940
`define UDP_LEN_SEQ      16'h0502
`define UDP_LEN_NOSEQ    16'h04FE
`define IP_TOTAL_SEQ     16'h0516
`define IP_TOTAL_NOSEQ   16'h0512

// Tail byte offsets.
`define T_FLAG           5'd5
`define T_SPEED          5'd8
`define T_STAMP          5'd10
`define T_MODE           5'd14
`define T_FACTORY        5'd15
`define T_UTC            5'd16
`define T_SEQ            5'd22

// Flag and return mode codes.
`define FLAG_NORMAL      8'h00
`define FLAG_HOT         8'h01
`define MODE_STRONGEST   8'h37
`define MODE_LAST        8'h38
`define MODE_DUAL        8'h39

// Register byte offsets on the APB.
`define REG_CTRL         12'h000
`define REG_MAC_LO       12'h004
`define REG_MAC_HI       12'h008
`define REG_SRC_IP       12'h00C
`define REG_DST_IP       12'h010
`define REG_STATUS       12'h014
`define REG_SEQ          12'h018
`define REG_TIME         12'h01C
`define REG_UTC_LO       12'h020
`define REG_UTC_HI       12'h024

// Reset values.
`define CTRL_RESET       32'h0000_0000
`define DST_IP_RESET     32'hFFFF_FFFF
`define SEQ_FIRST        32'h0000_0001

// Timing: shutdown delay in seconds and clock rate in Hz.
`define SHUTDOWN_S       60
`define CLK_HZ           100000000
`define SHUTDOWN_CYC     (40'd`SHUTDOWN_S * 40'd`CLK_HZ)
`define US_CYC           (`CLK_HZ / 1000000)

`endif

// ### framer_overheat.v
// Overheat shutdown sequencer: holds the flag while hot, counts the delay,
// then asserts power-down until the condition clears.
// Assumes the hot input is already synchronised to the clock.
`timescale 1ns/1ps
`include "udp_framer_consts.vh"

module framer_overheat
#(
   parameter [39:0] DELAY_CYC = `SHUTDOWN_CYC
)
(
   input  wire       clk,
   input  wire       rst_n,
   input  wire       hot,
   output reg        flag,
   output reg        power_down
);

   reg [39:0] count;

   // The flag tracks the hot condition; the delay starts at the first hot cycle.
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         flag       <= 1'b0;
         power_down <= 1'b0;
         count      <= 40'h00_0000_0000;
      end
      else if (hot)
      begin
         flag <= 1'b1;
         if (count >= DELAY_CYC - 40'h1)
            power_down <= 1'b1;
         else
            count <= count + 40'h1;
      end
      else
      begin
         // Clearing only when cool avoids flapping mid-countdown.
         flag       <= 1'b0;
         power_down <= 1'b0;
         count      <= 40'h00_0000_0000;
      end
   end

endmodule // framer_overheat

// ### udp_framer.v
// Point cloud UDP framer: header, streamed body, tail with optional counter.
// Assumes an APB master, a body source with valid/ready and a byte sink that
// accepts one byte per cycle while O_TX_VALID is high.
`timescale 1ns/1ps
`include "udp_framer_consts.vh"

module udp_framer
#(
   parameter [10:0] BODY_LEN  = 11'd1248,
   parameter [39:0] DELAY_CYC = `SHUTDOWN_CYC,
   parameter [7:0]  FACTORY   = 8'h5A        // Arbitrary factory code.
)
(
   // Clock and reset.
   input  wire        I_REF_CLK,
   input  wire        I_RST_N,
   // APB slave.
   input  wire        I_PSEL,
   input  wire        I_PENABLE,
   input  wire        I_PWRITE,
   input  wire [11:0] I_PADDR,
   input  wire [31:0] I_PWDATA,
   output reg  [31:0] O_PRDATA,
   output reg         O_PREADY,
   output reg         O_PSLVERR,
   // Sensor state.
   input  wire        I_HOT,
   input  wire [15:0] I_SPEED,
   // Body stream.
   input  wire [7:0]  I_BODY_DATA,
   input  wire        I_BODY_VALID,
   output reg         O_BODY_READY,
   // Frame output stream and overheat power-down.
   output reg  [7:0]  O_TX_DATA,
   output reg         O_TX_VALID,
   output reg         O_TX_LAST,
   output reg         O_POWER_DOWN
);

   localparam ST_IDLE = 2'd0;
   localparam ST_HDR  = 2'd1;
   localparam ST_BODY = 2'd2;
   localparam ST_TAIL = 2'd3;

   reg  [31:0] ctrl;       // [0] start, [1] sequence on, [3:2] return mode.
   reg  [31:0] mac_lo;
   reg  [15:0] mac_hi;
   reg  [31:0] src_ip;
   reg  [31:0] dst_ip;
   reg  [47:0] utc;
   reg  [31:0] seq;
   reg  [19:0] usec;
   reg  [6:0]  us_div;
   reg  [1:0]  state;
   reg  [10:0] idx;
   reg  [31:0] stamp;
   reg  [15:0] speed_q;
   reg         seq_on;     // Latched per frame so the length stays consistent.
   reg         hot_s1;
   reg         hot_s2;
   reg         pend;
   wire        flag;
   wire        power_down;
   wire        wr;
   wire        rd;
   wire [7:0]  mode_byte;
   reg  [7:0]  hdr_byte;
   reg  [7:0]  tail_byte;
   reg  [10:0] tail_len;

   // Pick the nth byte of a big-endian 32-bit word.
   function [7:0] be32;
      input [31:0] w;
      input [1:0]  n;
      begin
         be32 = w[31 - 8 * n -: 8];
      end
   endfunction

   assign wr = I_PSEL & I_PENABLE & I_PWRITE;
   assign rd = I_PSEL & I_PENABLE & ~I_PWRITE;
   assign mode_byte = (ctrl[3:2] == 2'd1) ? `MODE_LAST :
                      (ctrl[3:2] == 2'd2) ? `MODE_DUAL : `MODE_STRONGEST;

   // The hot pin comes from outside, so it is synchronised first.
   always @(posedge I_REF_CLK)
   begin
      if (!I_RST_N)
      begin
         hot_s1 <= 1'b0;
         hot_s2 <= 1'b0;
      end
      else
      begin
         hot_s1 <= I_HOT;
         hot_s2 <= hot_s1;
      end
   end

   framer_overheat #(.DELAY_CYC(DELAY_CYC)) u_overheat
   (
      .clk        (I_REF_CLK),
      .rst_n      (I_RST_N),
      .hot        (hot_s2),
      .flag       (flag),
      .power_down (power_down)
   );

   // Microsecond time within the second, wrapping at one second.
   always @(posedge I_REF_CLK)
   begin
      if (!I_RST_N)
      begin
         us_div <= 7'd0;
         usec   <= 20'd0;
      end
      else if (us_div == `US_CYC - 1)
      begin
         us_div <= 7'd0;
         usec   <= (usec == 20'd999999) ? 20'd0 : usec + 20'd1;
      end
      else
         us_div <= us_div + 7'd1;
   end

   // Header byte mux, registered on output.
   always @*
   begin
      hdr_byte = 8'h00;
      case (idx[5:0])
         6'd0, 6'd1, 6'd2, 6'd3, 6'd4, 6'd5: hdr_byte = 8'hFF;
         6'd6:  hdr_byte = mac_hi[15:8];
         6'd7:  hdr_byte = mac_hi[7:0];
         6'd8:  hdr_byte = be32(mac_lo, 2'd0);
         6'd9:  hdr_byte = be32(mac_lo, 2'd1);
         6'd10: hdr_byte = be32(mac_lo, 2'd2);
         6'd11: hdr_byte = be32(mac_lo, 2'd3);
         6'd12: hdr_byte = `ETHTYPE_HI;
         6'd13: hdr_byte = `ETHTYPE_LO;
         6'd14: hdr_byte = 8'h45;
         6'd16: hdr_byte = be32({`IP_TOTAL_SEQ, `IP_TOTAL_NOSEQ}, {~seq_on, 1'b0});
         6'd17: hdr_byte = be32({`IP_TOTAL_SEQ, `IP_TOTAL_NOSEQ}, {~seq_on, 1'b1});
         6'd20: hdr_byte = 8'h40;                             // Do not fragment.
         6'd22: hdr_byte = 8'h40;                             // Time to live.
         6'd23: hdr_byte = 8'h11;                             // UDP protocol.
         6'd26: hdr_byte = be32(src_ip, 2'd0);
         6'd27: hdr_byte = be32(src_ip, 2'd1);
         6'd28: hdr_byte = be32(src_ip, 2'd2);
         6'd29: hdr_byte = be32(src_ip, 2'd3);
         6'd30: hdr_byte = be32(dst_ip, 2'd0);
         6'd31: hdr_byte = be32(dst_ip, 2'd1);
         6'd32: hdr_byte = be32(dst_ip, 2'd2);
         6'd33: hdr_byte = be32(dst_ip, 2'd3);
         6'd34: hdr_byte = be32({`UDP_SRC_PORT, `UDP_DST_PORT}, 2'd0);
         6'd35: hdr_byte = be32({`UDP_SRC_PORT, `UDP_DST_PORT}, 2'd1);
         6'd36: hdr_byte = be32({`UDP_SRC_PORT, `UDP_DST_PORT}, 2'd2);
         6'd37: hdr_byte = be32({`UDP_SRC_PORT, `UDP_DST_PORT}, 2'd3);
         6'd38: hdr_byte = be32({`UDP_LEN_SEQ, `UDP_LEN_NOSEQ}, {~seq_on, 1'b0});
         6'd39: hdr_byte = be32({`UDP_LEN_SEQ, `UDP_LEN_NOSEQ}, {~seq_on, 1'b1});
         // Checksums are sent as zero; a zero UDP checksum means none.
         default: hdr_byte = 8'h00;
      endcase
   end

   // Tail byte mux; unlisted offsets are the reserved bytes.
   always @*
   begin
      tail_byte = 8'h00;
      tail_len  = seq_on ? `TAIL_LEN_SEQ : `TAIL_LEN_NOSEQ;
      case (idx[4:0])
         `T_FLAG:       tail_byte = flag ? `FLAG_HOT : `FLAG_NORMAL;
         `T_SPEED:      tail_byte = speed_q[7:0];
         5'd9:          tail_byte = speed_q[15:8];
         `T_STAMP:      tail_byte = stamp[7:0];
         5'd11:         tail_byte = stamp[15:8];
         5'd12:         tail_byte = stamp[23:16];
         5'd13:         tail_byte = stamp[31:24];
         `T_MODE:       tail_byte = mode_byte;
         `T_FACTORY:    tail_byte = FACTORY;
         5'd16:         tail_byte = utc[47:40];
         5'd17:         tail_byte = utc[39:32];
         5'd18:         tail_byte = utc[31:24];
         5'd19:         tail_byte = utc[23:16];
         5'd20:         tail_byte = utc[15:8];
         5'd21:         tail_byte = utc[7:0];
         `T_SEQ:        tail_byte = seq[7:0];
         5'd23:         tail_byte = seq[15:8];
         5'd24:         tail_byte = seq[23:16];
         5'd25:         tail_byte = seq[31:24];
         default:       tail_byte = 8'h00;
      endcase
   end

   // Frame sequencer: header, body, tail, one byte per cycle.
   always @(posedge I_REF_CLK)
   begin
      if (!I_RST_N)
      begin
         state        <= ST_IDLE;
         idx          <= 11'd0;
         seq_on       <= 1'b0;
         seq          <= `SEQ_FIRST;
         stamp        <= 32'h0000_0000;
         speed_q      <= 16'h0000;
         O_TX_DATA    <= 8'h00;
         O_TX_VALID   <= 1'b0;
         O_TX_LAST    <= 1'b0;
         O_BODY_READY <= 1'b0;
      end
      else
      begin
         O_TX_VALID <= 1'b0;
         O_TX_LAST  <= 1'b0;
         case (state)
            ST_IDLE:
            begin
               idx <= 11'd0;
               if (pend)
               begin
                  seq_on  <= ctrl[1];
                  stamp   <= {12'h000, usec};
                  speed_q <= I_SPEED;
                  state   <= ST_HDR;
               end
            end
            ST_HDR:
            begin
               O_TX_DATA  <= hdr_byte;
               O_TX_VALID <= 1'b1;
               if (idx == `HDR_LEN - 11'd1)
               begin
                  idx          <= 11'd0;
                  state        <= ST_BODY;
                  O_BODY_READY <= 1'b1;
               end
               else
                  idx <= idx + 11'd1;
            end
            ST_BODY:
            begin
               // Stalls while the source has no byte; the sink never waits.
               if (I_BODY_VALID & O_BODY_READY)
               begin
                  O_TX_DATA  <= I_BODY_DATA;
                  O_TX_VALID <= 1'b1;
                  if (idx == BODY_LEN - 11'd1)
                  begin
                     idx          <= 11'd0;
                     O_BODY_READY <= 1'b0;
                     state        <= ST_TAIL;
                  end
                  else
                     idx <= idx + 11'd1;
               end
            end
            ST_TAIL:
            begin
               O_TX_DATA  <= tail_byte;
               O_TX_VALID <= 1'b1;
               if (idx == tail_len - 11'd1)
               begin
                  O_TX_LAST <= 1'b1;
                  state     <= ST_IDLE;
                  if (seq_on)
                     seq <= (seq == 32'hFFFF_FFFF) ? `SEQ_FIRST : seq + 32'd1;
               end
               else
                  idx <= idx + 11'd1;
            end
            default: state <= ST_IDLE;
         endcase
         if (wr & O_PREADY & (I_PADDR == `REG_SEQ))
            seq <= I_PWDATA;                                  // Preset, mainly to reach the wrap.
      end
   end

   // APB slave: zero-wait answers, error on unmapped addresses.
   always @(posedge I_REF_CLK)
   begin
      if (!I_RST_N)
      begin
         ctrl         <= `CTRL_RESET;
         mac_lo       <= 32'h0000_0000;
         mac_hi       <= 16'h0000;
         src_ip       <= 32'h0000_0000;
         dst_ip       <= `DST_IP_RESET;
         utc          <= 48'h0000_0000_0000;
         pend         <= 1'b0;
         O_PRDATA     <= 32'h0000_0000;
         O_PREADY     <= 1'b0;
         O_PSLVERR    <= 1'b0;
         O_POWER_DOWN <= 1'b0;
      end
      else
      begin
         O_POWER_DOWN <= power_down;
         O_PREADY     <= I_PSEL & ~I_PENABLE;
         O_PSLVERR    <= 1'b0;
         if (state == ST_IDLE)
            pend <= 1'b0;   // Consumed in idle; a later start in this block wins.
         if (I_PSEL & ~I_PENABLE)
         begin
            // Setup phase: decode now so the access phase finishes in one cycle.
            case (I_PADDR)
               `REG_CTRL:   O_PRDATA <= {28'h0, ctrl[3:1], 1'b0};
               `REG_MAC_LO: O_PRDATA <= mac_lo;
               `REG_MAC_HI: O_PRDATA <= {16'h0000, mac_hi};
               `REG_SRC_IP: O_PRDATA <= src_ip;
               `REG_DST_IP: O_PRDATA <= dst_ip;
               `REG_STATUS: O_PRDATA <= {28'h0, power_down, flag, pend, state != ST_IDLE};
               `REG_SEQ:    O_PRDATA <= seq;
               `REG_TIME:   O_PRDATA <= {12'h000, usec};
               `REG_UTC_LO: O_PRDATA <= utc[31:0];
               `REG_UTC_HI: O_PRDATA <= {16'h0000, utc[47:32]};
               default:
               begin
                  O_PRDATA  <= 32'h0000_0000;
                  O_PSLVERR <= 1'b1;
               end
            endcase
         end
         if (wr & O_PREADY)
         begin
            case (I_PADDR)
               `REG_CTRL:
               begin
                  ctrl <= {28'h0, I_PWDATA[3:1], 1'b0};
                  if (I_PWDATA[0])
                     pend <= 1'b1;
               end
               `REG_MAC_LO: mac_lo <= I_PWDATA;
               `REG_MAC_HI: mac_hi <= I_PWDATA[15:0];
               `REG_SRC_IP: src_ip <= I_PWDATA;
               `REG_DST_IP: dst_ip <= I_PWDATA;
               `REG_UTC_LO: utc[31:0] <= I_PWDATA;
               `REG_UTC_HI: utc[47:32] <= I_PWDATA[15:0];
               default: ;
            endcase
         end
         if (rd & O_PREADY)
            O_PRDATA <= O_PRDATA;
      end
   end

endmodule // udp_framer

// ### framer_properties.sv
// Checker for the UDP framer: frame layout and overheat timing.
// Assumes it is bound to the framer top and sees only its ports.
`timescale 1ns/1ps
module framer_properties
#(
   parameter [10:0] BODY_LEN  = 11'd6,
   parameter [39:0] DELAY_CYC = 40'd40
)
(
   input wire       I_REF_CLK,
   input wire       I_RST_N,
   input wire       I_HOT,
   input wire [7:0] O_TX_DATA,
   input wire       O_TX_VALID,
   input wire       O_TX_LAST,
   input wire       O_BODY_READY,
   input wire       O_POWER_DOWN
);
   localparam [10:0] TB = 11'd42 + BODY_LEN;
   reg [10:0] pos;
   reg [7:0]  hot_cnt;
   reg [7:0]  cold_cnt;
   default clocking @(posedge I_REF_CLK); endclocking
   default disable iff (!I_RST_N);
   // Byte position in the frame, and saturating run lengths of the hot input.
   always @(posedge I_REF_CLK)
   begin
      if (!I_RST_N)
      begin
         pos <= 11'h000;
         hot_cnt <= 8'h00;
         cold_cnt <= 8'h00;
      end
      else
      begin
         if (O_TX_VALID)
            pos <= O_TX_LAST ? 11'h000 : pos + 11'h001;
         hot_cnt <= I_HOT ? hot_cnt + {7'h00, ~&hot_cnt} : 8'h00;
         cold_cnt <= I_HOT ? 8'h00 : cold_cnt + {7'h00, ~&cold_cnt};
      end
   end
   bcast_dst_a: assert property (O_TX_VALID && pos < 11'd6 |-> O_TX_DATA == 8'hFF)
      else $error("Destination byte is not broadcast.");
   ethertype_a: assert property (O_TX_VALID && pos == 11'd12 |-> O_TX_DATA == 8'h08 ##1 O_TX_DATA == 8'h00)
      else $error("Type field is wrong.");
   hdr_contig_a: assert property (O_TX_VALID && pos < 11'd41 |=> O_TX_VALID)
      else $error("Header bytes are not contiguous.");
   body_hold_a: assert property (O_TX_VALID && pos < 11'd41 |-> !O_BODY_READY)
      else $error("Body requested during the header.");
   udp_ports_a: assert property (O_TX_VALID && pos == 11'd34 |-> O_TX_DATA == 8'h27 ##1 O_TX_DATA == 8'h10 ##1 O_TX_DATA == 8'h09 ##1 O_TX_DATA == 8'h40)
      else $error("Port fields are wrong.");
   udp_len_a: assert property (O_TX_VALID && pos == 11'd38 |-> (O_TX_DATA == 8'h05 ##1 O_TX_DATA == 8'h02) or (O_TX_DATA == 8'h04 ##1 O_TX_DATA == 8'hFE))
      else $error("Length field is wrong.");
   frame_len_a: assert property (O_TX_VALID && O_TX_LAST |-> pos == TB + 11'd25 || pos == TB + 11'd21)
      else $error("Frame length is wrong.");
   resv_zero_a: assert property (O_TX_VALID && pos >= TB && (pos < TB + 11'd5 || pos == TB + 11'd6 || pos == TB + 11'd7) |-> O_TX_DATA == 8'h00)
      else $error("Reserved tail byte is not zero.");
   flag_code_a: assert property (O_TX_VALID && pos == TB + 11'd5 && (&hot_cnt || &cold_cnt) |-> O_TX_DATA == {7'h00, I_HOT})
      else $error("Shutdown flag byte is wrong.");
   mode_code_a: assert property (O_TX_VALID && pos == TB + 11'd14 |-> O_TX_DATA inside {8'h37, 8'h38, 8'h39})
      else $error("Return mode byte is out of range.");
   pd_delay_a: assert property ($rose(O_POWER_DOWN) |-> hot_cnt >= DELAY_CYC)
      else $error("Power down came too early.");
   pd_bound_a: assert property (hot_cnt == DELAY_CYC + 40'd8 |-> O_POWER_DOWN)
      else $error("Power down came too late.");
   pd_release_a: assert property (cold_cnt == 8'd8 |-> !O_POWER_DOWN)
      else $error("Power down held after cooling.");
   cover property ($rose(O_POWER_DOWN));
   cover property (O_TX_VALID && O_TX_LAST && pos == TB + 11'd25);
   cover property (O_TX_VALID && pos == TB + 11'd14 && O_TX_DATA == 8'h39);
endmodule // framer_properties

// ### frame_host.sv
// Host model that receives framed point cloud packets and keeps the last one.
// Assumes a byte stream that it accepts on every cycle; frames of at most 128 bytes.
`timescale 1ns/1ps
module frame_host
(
   input wire       clk,
   input wire       rst_n,
   input wire [7:0] data,
   input wire       valid,
   input wire       last
);
   reg [7:0]  pkt [0:127];
   reg [10:0] cnt;
   reg [10:0] len;
   integer    frames;
   // Store each byte; reserved bytes are kept but given no meaning.
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         cnt <= 11'h000;
         len <= 11'h000;
         frames <= 0;
      end
      else if (valid)
      begin
         pkt[cnt[6:0]] <= data;
         cnt <= last ? 11'h000 : cnt + 11'h001;
         if (last)
         begin
            len <= cnt + 11'h001;
            frames <= frames + 1;
         end
      end
   end
endmodule // frame_host

// ### tb_top.sv
// Testbench for the UDP framer: registers, frame content, counter, overheat.
// Assumes the host model captures frames; the checker is bound at the foot.
`timescale 1ns/1ps
module tb_top;
   localparam [10:0] BL = 11'd6;
   logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, hot = 0, bvalid = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, r, sip = 32'hC0A8_01C9, seqv = 32'h1;
   logic        pready, pslverr, bready, txv, txl, pd, e;
   logic [7:0]  bdata = 8'hA0, txd, flag = 8'h00;
   logic [15:0] speed = 16'h0000;
   logic [47:0] mac = 48'h0211_2233_4455, utc = 48'h1805_0C0A_1E2D;
   integer      cyc = 0, miscompares = 0, compares = 0;
   always #5 clk = ~clk;
   udp_framer #(.BODY_LEN(BL), .DELAY_CYC(40'd40)) dut
   (
      .I_REF_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
      .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
      .O_PSLVERR(pslverr), .I_HOT(hot), .I_SPEED(speed), .I_BODY_DATA(bdata),
      .I_BODY_VALID(bvalid), .O_BODY_READY(bready), .O_TX_DATA(txd), .O_TX_VALID(txv),
      .O_TX_LAST(txl), .O_POWER_DOWN(pd)
   );
   frame_host host (.clk(clk), .rst_n(rst_n), .data(txd), .valid(txv), .last(txl));
   // Body source stalls two cycles in four, so the framer must wait for it.
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      bvalid <= cyc[1];
      if (txv && txl)
         bdata <= 8'hA0;
      else if (bvalid && bready)
         bdata <= bdata + 8'h01;
      if (cyc == 20000)
      begin
         miscompares++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      compares++;
      if (g !== x)
      begin
         miscompares++;
         $display("ERROR at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   // One APB transfer; the request is held until pready is seen high.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      // No cycle count is assumed; only the bench watchdog ends this wait.
      while (pready !== 1'b1)
         @(posedge clk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   // Starts one frame and compares every byte the host received; the time stamp bytes are only range checked.
   task automatic t_frame(input logic s, input logic [1:0] m);
      integer i, f, n;
      logic [335:0] hd;
      logic [207:0] tl;
      f = host.frames;
      n = 0;
      speed <= 16'h0E10 + m;
      apb(1'b1, 12'h000, {28'h0, m, s, 1'b1});
      while (host.frames == f && n < 2000)
      begin
         @(posedge clk);
         n++;
      end
      chk(host.frames - f, 32'd1);
      hd = {48'hFFFF_FFFF_FFFF, mac, 16'h0800, 16'h4500, s ? 16'h0516 : 16'h0512, 16'h0,
            16'h4000, 16'h4011, 16'h0, sip, 32'hFFFF_FFFF, 32'h2710_0940,
            s ? 16'h0502 : 16'h04FE, 16'h0};
      tl = {40'h0, flag, 16'h0, speed[7:0], speed[15:8], 32'h0, 8'h37 + m, 8'h5A, utc,
            seqv[7:0], seqv[15:8], seqv[23:16], seqv[31:24]};
      chk(host.len, BL + (s ? 11'd68 : 11'd64));
      for (i = 0; i < 42; i++)
         chk(host.pkt[i], hd[335 - 8 * i -: 8]);
      for (i = 0; i < BL; i++)
         chk(host.pkt[42 + i], 8'hA0 + i);
      for (i = 0; i < (s ? 26 : 22); i++)
         if (i < 10 || i > 13)
            chk(host.pkt[42 + BL + i], tl[207 - 8 * i -: 8]);
      chk({31'h0, {host.pkt[55 + BL], host.pkt[54 + BL], host.pkt[53 + BL],
                   host.pkt[52 + BL]} <= 32'd1000000}, 32'h1);
      if (s)
         seqv = (seqv == 32'hFFFF_FFFF) ? 32'h1 : seqv + 32'h1;
   endtask
   task automatic t_regs();
      apb(1'b0, 12'h000, 32'h0);
      chk(r, 32'h0);
      apb(1'b0, 12'h018, 32'h0);
      chk(r, 32'h1);
      apb(1'b0, 12'h010, 32'h0);
      chk(r, 32'hFFFF_FFFF);
      apb(1'b1, 12'h028, 32'h1);
      chk(e, 1'b1);
      apb(1'b0, 12'h028, 32'h0);
      chk({e, r}, {1'b1, 32'h0});
      apb(1'b1, 12'h004, mac[31:0]);
      apb(1'b1, 12'h008, {16'h0, mac[47:32]});
      apb(1'b1, 12'h00C, sip);
      apb(1'b1, 12'h020, utc[31:0]);
      apb(1'b1, 12'h024, {16'h0, utc[47:32]});
   endtask
   task automatic t_modes();
      for (int m = 0; m < 3; m++)
         t_frame(1'b1, m[1:0]);
      t_frame(1'b0, 2'd0);
   endtask
   task automatic t_wrap();
      apb(1'b1, 12'h018, 32'hFFFF_FFFF);
      seqv = 32'hFFFF_FFFF;
      t_frame(1'b1, 2'd1);
      t_frame(1'b1, 2'd1);
   endtask
   // Hot input held past the delay, then cleared; flag and power down follow.
   task automatic t_hot();
      integer n;
      n = 0;
      hot <= 1'b1;
      flag = 8'h01;
      repeat (8) @(posedge clk);
      t_frame(1'b1, 2'd2);
      while (pd !== 1'b1 && n < 100)
      begin
         @(posedge clk);
         n++;
      end
      chk(pd, 1'b1);
      hot <= 1'b0;
      flag = 8'h00;
      repeat (12) @(posedge clk);
      chk(pd, 1'b0);
      t_frame(1'b1, 2'd0);
   endtask
   // Main sequence: reset for four cycles, then each scenario in turn.
   initial
   begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_regs();
      t_modes();
      t_wrap();
      t_hot();
      give_verdict();
   end
endmodule // tb_top
bind udp_framer framer_properties #(.BODY_LEN(BODY_LEN), .DELAY_CYC(DELAY_CYC)) props
(
   .I_REF_CLK    (I_REF_CLK),
   .I_RST_N      (I_RST_N),
   .I_HOT        (I_HOT),
   .O_TX_DATA    (O_TX_DATA),
   .O_TX_VALID   (O_TX_VALID),
   .O_TX_LAST    (O_TX_LAST),
   .O_BODY_READY (O_BODY_READY),
   .O_POWER_DOWN (O_POWER_DOWN)
);
